// *** verilog/cph_pkg.sv ***
// Constants and types for the core pause and forced debug halt control block.
// Assumes a CSR port carrying 12-bit addresses and 32-bit data on one core clock.
package cph_pkg;

	localparam logic [11:0] CPH_ADDR_PAUSE     = 12'h7c2;
	localparam logic [11:0] CPH_ADDR_THRESHOLD = 12'h7ce;
	localparam logic [11:0] CPH_ADDR_STATUS    = 12'h7cf;

	localparam int          CPH_THR_EN_BIT     = 0;
	localparam int          CPH_THR_EXP_LSB    = 1;
	localparam int          CPH_THR_EXP_W      = 5;
	localparam int          CPH_STS_FETCH_BIT  = 0;
	localparam int          CPH_STS_LSU_BIT    = 1;

	localparam logic [31:0] CPH_PAUSE_RST      = 32'h0;
	localparam logic        CPH_EN_RST         = 1'b0;
	localparam logic [4:0]  CPH_EXP_RST        = 5'h0;
	localparam logic [1:0]  CPH_STS_RST        = 2'h0;

	typedef enum logic [1:0] {
		CPH_RUN,
		CPH_WAIT_QUIESCE,
		CPH_DBG_HALTED
	} cph_dbg_state_t;

endpackage

// *** verilog/cph_timeout.sv ***
// Forced debug halt timeout counter and threshold compare.
// Assumes the control module supplies count/clear strobes on the same clock.
module cph_timeout
	import cph_pkg::*;
#(
	parameter int CNT_W = 32
)
(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	// Control
	input  wire logic                     count_en,
	input  wire logic                     clear,
	input  wire logic [CPH_THR_EXP_W-1:0] exponent,
	// Result
	output logic                          expired
);

	logic [CNT_W-1:0] count_r;
	logic [CNT_W:0]   limit;

	// The counter saturates so a very long wait cannot wrap back below the limit.
	always_ff @(posedge clk)
	begin
		if (sys_rst || clear)
			count_r <= '0;
		else if (count_en && count_r != '1)
			count_r <= count_r + CNT_W'(1);
	end

	assign limit   = {{CNT_W{1'b0}}, 1'b1} << exponent;
	assign expired = {1'b0, count_r} >= limit;

endmodule // cph_timeout

// *** verilog/cph_core_ctrl.sv ***
// Core pause counter and forced debug halt sequencing with their CSRs.
// Assumes CSR reads are combinationally addressed and captured one cycle later,
// and that the pipeline stalls while pause_active is high.
module cph_core_ctrl
	import cph_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// CSR port
	input  wire logic        csr_wr,
	input  wire logic        csr_rd,
	input  wire logic [11:0] csr_addr,
	input  wire logic [31:0] csr_wdata,
	output logic [31:0]      csr_rdata,
	output logic             csr_hit,
	// Pipeline events
	input  wire logic        irq_pending,
	input  wire logic        wfi_exec,
	input  wire logic        pmu_halted,
	// Debug halt
	input  wire logic        dbg_halt_req,
	input  wire logic        dbg_resume,
	input  wire logic        lsu_pending,
	input  wire logic        fetch_pending,
	input  wire logic        core_quiesced,
	// Results
	output logic             pause_active,
	output logic             wfi_stall,
	output logic             lsu_abort,
	output logic             fetch_abort,
	output logic             debug_halted_state
);

	////////////////////////////////////////////////////////////////////////////

	function automatic logic csr_sel(input logic [11:0] a, input logic [11:0] b);
		return a == b;
	endfunction

	logic [31:0]    pause_r;
	logic           en_r;
	logic [4:0]     exp_r;
	logic [1:0]     sts_r;
	cph_dbg_state_t st_r;
	logic           expired;
	logic           to_clear;
	logic           to_count;
	logic           enter_halt;
	logic           force_halt;

	////////////////////////////////////////////////////////////////////////////
	// Pause counter. The stall shows one cycle after the count changes, which
	// is the skid the pipeline tolerates.

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pause_r <= CPH_PAUSE_RST;
		else if (csr_wr && csr_sel(csr_addr, CPH_ADDR_PAUSE))
			pause_r <= csr_wdata;
		else if (irq_pending)
			pause_r <= '0;
		else if (pmu_halted)
			pause_r <= pause_r;
		else if (pause_r != '0)
			pause_r <= pause_r - 32'h1;
	end

	// The pause is only a stall request; no power state is entered here.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pause_active <= 1'b0;
		else
			pause_active <= pause_r != '0 && !irq_pending;
	end

	// Wait-for-interrupt never stalls.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			wfi_stall <= 1'b0;
		else
			wfi_stall <= wfi_exec & 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Threshold register.

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			en_r  <= CPH_EN_RST;
			exp_r <= CPH_EXP_RST;
		end
		else if (csr_wr && csr_sel(csr_addr, CPH_ADDR_THRESHOLD))
		begin
			en_r  <= csr_wdata[CPH_THR_EN_BIT];
			exp_r <= csr_wdata[CPH_THR_EXP_LSB +: CPH_THR_EXP_W];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Debug halt sequencing.

	assign to_count   = st_r == CPH_WAIT_QUIESCE && en_r && (lsu_pending || fetch_pending);
	assign to_clear   = st_r == CPH_DBG_HALTED && dbg_resume;
	assign force_halt = to_count && expired;
	assign enter_halt = st_r == CPH_WAIT_QUIESCE
		&& ((!lsu_pending && !fetch_pending && core_quiesced) || force_halt);

	cph_timeout #(
		.CNT_W (32)
	) u_timeout (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.count_en (to_count),
		.clear    (to_clear),
		.exponent (exp_r),
		.expired  (expired)
	);

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_r <= CPH_RUN;
		else
		begin
			case (st_r)
				CPH_RUN:
					if (dbg_halt_req)
						st_r <= CPH_WAIT_QUIESCE;
				CPH_WAIT_QUIESCE:
					if (enter_halt)
						st_r <= CPH_DBG_HALTED;
				CPH_DBG_HALTED:
					if (dbg_resume)
						st_r <= CPH_RUN;
				default:
					st_r <= CPH_RUN;
			endcase
		end
	end

	// Abort strobes last one cycle, on the cycle the forced entry is taken.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			lsu_abort   <= 1'b0;
			fetch_abort <= 1'b0;
		end
		else
		begin
			lsu_abort   <= force_halt && lsu_pending;
			fetch_abort <= force_halt && fetch_pending;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			debug_halted_state <= 1'b0;
		else
			debug_halted_state <= (st_r == CPH_DBG_HALTED && !dbg_resume) || enter_halt;
	end

	// Halt entry overrides a same-cycle debugger write so the latched result is kept.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			sts_r <= CPH_STS_RST;
		else if (enter_halt)
		begin
			sts_r[CPH_STS_LSU_BIT]   <= force_halt && lsu_pending;
			sts_r[CPH_STS_FETCH_BIT] <= force_halt && fetch_pending;
		end
		else if (csr_wr && csr_sel(csr_addr, CPH_ADDR_STATUS))
			sts_r <= csr_wdata[1:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// Read path.

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			csr_rdata <= 32'h0;
			csr_hit   <= 1'b0;
		end
		else
		begin
			csr_rdata <= 32'h0;
			csr_hit   <= 1'b0;
			if (csr_rd || csr_wr)
			begin
				if (csr_sel(csr_addr, CPH_ADDR_PAUSE))
				begin
					csr_rdata <= 32'h0;
					csr_hit   <= 1'b1;
				end
				else if (csr_sel(csr_addr, CPH_ADDR_THRESHOLD))
				begin
					csr_rdata <= {26'h0, exp_r, en_r};
					csr_hit   <= 1'b1;
				end
				else if (csr_sel(csr_addr, CPH_ADDR_STATUS))
				begin
					csr_rdata <= {30'h0, sts_r};
					csr_hit   <= 1'b1;
				end
			end
		end
	end

endmodule // cph_core_ctrl

// *** testbench/cph_chk.sv ***
// Port checker for the pause counter and forced debug halt block.
// Assumes it is bound onto cph_core_ctrl with ports matched by name.
module cph_chk
	import cph_pkg::*;
(
	input wire logic        clk, sys_rst, csr_wr, csr_rd, csr_hit, irq_pending, pmu_halted,
	input wire logic        dbg_resume, lsu_pending, wfi_stall, pause_active,
	input wire logic        lsu_abort, fetch_abort, debug_halted_state,
	input wire logic [11:0] csr_addr,
	input wire logic [31:0] csr_wdata, csr_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire pw = csr_wr && csr_addr == CPH_ADDR_PAUSE;
	wire hole = (csr_wr || csr_rd) && csr_addr != CPH_ADDR_PAUSE && csr_addr != CPH_ADDR_THRESHOLD
		&& csr_addr != CPH_ADDR_STATUS;
	////////////////////////////////////////////////////////////////
	property p_start; pw && csr_wdata != '0 ##1 !irq_pending |=> pause_active; endproperty
	a_start: assert property (p_start) else $error("pause did not start");
	property p_irq; irq_pending && !csr_wr |=> !pause_active; endproperty
	a_irq: assert property (p_irq) else $error("interrupt did not end pause");
	property p_freeze;
		pmu_halted && !irq_pending && !csr_wr ##1 pause_active && !irq_pending |=> pause_active;
	endproperty
	a_freeze: assert property (p_freeze) else $error("pause ran while halted");
	property p_wfi; !wfi_stall; endproperty
	a_wfi: assert property (p_wfi) else $error("wfi stalled");
	property p_rd; csr_rd && csr_addr == CPH_ADDR_PAUSE |=> csr_rdata == '0; endproperty
	a_rd: assert property (p_rd) else $error("pause read not zero");
	property p_hole; hole |=> !csr_hit && csr_rdata == '0; endproperty
	a_hole: assert property (p_hole) else $error("unmapped access answered");
	property p_abort; lsu_abort || fetch_abort |-> $rose(debug_halted_state); endproperty
	a_abort: assert property (p_abort) else $error("abort without halt entry");
	property p_lsu; lsu_abort |-> $past(lsu_pending); endproperty
	a_lsu: assert property (p_lsu) else $error("abort with nothing pending");
	property p_exit; debug_halted_state && dbg_resume |=> !debug_halted_state; endproperty
	a_exit: assert property (p_exit) else $error("halt not left");
endmodule // cph_chk

bind cph_core_ctrl cph_chk u_chk (.*);

// *** testbench/cph_bus_model.sv ***
// Bus-side model: holds load/store or fetch transactions for a set latency.
// Assumes the core clock; an abort pulse drops the pending line at once.
module cph_bus_model
(
	input wire logic        clk, go_lsu, go_fetch, lsu_abort, fetch_abort,
	input wire logic [31:0] lat,
	output logic            lsu_pending = '0, fetch_pending = '0, core_quiesced
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] left_r = '0;
	assign core_quiesced = !lsu_pending && !fetch_pending;
	always @(posedge clk)
	begin
		left_r <= (go_lsu || go_fetch) ? lat : left_r - 32'(left_r != '0);
		lsu_pending <= go_lsu || (lsu_pending && left_r > 1 && !lsu_abort);
		fetch_pending <= go_fetch || (fetch_pending && left_r > 1 && !fetch_abort);
	end
endmodule // cph_bus_model

// *** testbench/core_pause_forced_halt_bench.sv ***
// Self-checking bench for cph_core_ctrl with a random seeded stimulus.
// Assumes cph_pkg, the design, checker and bus model are compiled first.
module core_pause_forced_halt_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cph_pkg::*;
	logic clk = '0, sys_rst = '1, csr_wr = '0, csr_rd = '0, irq_pending = '0, wfi_exec = '0, pmu_halted = '0;
	logic dbg_halt_req = '0, dbg_resume = '0, go_lsu = '0, go_fetch = '0, csr_hit, hit, pause_active, wfi_stall;
	logic lsu_abort, fetch_abort, debug_halted_state, lsu_pending, fetch_pending, core_quiesced;
	logic [11:0] csr_addr = '0;
	logic [31:0] csr_wdata = '0, csr_rdata, lat = '0, n, seen, act, base;
	int miscompares = 0, tests_run = 0;
	cph_core_ctrl DUT (.*);
	cph_bus_model u_bus (.*);
	initial forever #10 clk = !clk;
	always @(posedge clk) act <= sys_rst ? 32'h0 : act + 32'(pause_active);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		{csr_wr, csr_rd, csr_addr, csr_wdata} <= {w, !w, a, d};
		@(posedge clk);
		{csr_wr, csr_rd} <= '0;
		// The answer stands only until the next edge, so it is taken just after this one.
		#1 {hit, seen} = {csr_hit, csr_rdata};
		@(posedge clk);
	endtask
	task automatic halt(input logic [31:0] thr, input logic l, f, input logic [31:0] lt, input logic [1:0] st, h);
		acc(1, CPH_ADDR_THRESHOLD, thr);
		{dbg_halt_req, go_lsu, go_fetch, lat} <= {1'h1, l, f, lt};
		@(posedge clk);
		{dbg_halt_req, go_lsu, go_fetch} <= '0;
		repeat (40) @(posedge clk);
		#1 chk(debug_halted_state, h);
		for (int i = 0; i < 300 && !debug_halted_state; i++) @(posedge clk);
		@(posedge clk);
		acc(0, CPH_ADDR_STATUS, '0);
		chk(seen, st);
		dbg_resume <= '1;
		@(posedge clk);
		dbg_resume <= '0;
		$display("halt test done");
	endtask
	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#300us;
		miscompares++;
		print_verdict();
	end
	initial
	begin
		void'($urandom(44));
		repeat (12) @(posedge clk);
		sys_rst <= '0;
		@(posedge clk);
		acc(0, CPH_ADDR_THRESHOLD, '0);
		chk(seen, '0);
		acc(0, 12'h7c3, '1);
		chk(32'(hit), '0);
		chk(seen, '0);
		n = $urandom;
		acc(1, CPH_ADDR_THRESHOLD, n);
		acc(0, CPH_ADDR_THRESHOLD, '0);
		chk(seen, n & 32'h3f);
		n = 32'h8 + $urandom % 32'h10;
		base = act;
		acc(1, CPH_ADDR_PAUSE, n);
		acc(0, CPH_ADDR_PAUSE, '0);
		chk(seen, '0);
		repeat (40) @(posedge clk);
		chk(32'(act - base + 32'h3 > n && act - base < n + 32'h3), 32'h1);
		// A short count, so that only a working freeze keeps the pause alive.
		acc(1, CPH_ADDR_PAUSE, 32'h10);
		{pmu_halted, wfi_exec} <= 2'h3;
		@(posedge clk);
		wfi_exec <= '0;
		repeat (100) @(posedge clk);
		#1 chk({pause_active, wfi_stall}, 32'h2);
		@(posedge clk);
		{pmu_halted, irq_pending} <= 2'h1;
		@(posedge clk);
		irq_pending <= '0;
		repeat (2) @(posedge clk);
		#1 chk(pause_active, '0);
		@(posedge clk);
		$display("pause test done");
		halt(32'h0, 0, 0, 32'h0, 2'h0, 1);
		halt(32'h1 | ($urandom % 32'h4 + 32'h1) << 1, 1, 0, 32'h200, 2'h2, 1);
		halt(32'h5, 1, 0, 32'h2, 2'h0, 1);
		halt(32'h7, 0, 1, 32'h200, 2'h1, 1);
		acc(1, CPH_ADDR_STATUS, '0);
		acc(0, CPH_ADDR_STATUS, '0);
		chk(seen, '0);
		halt(32'h0, 1, 0, 32'h80, 2'h0, 0);
		acc(1, CPH_ADDR_THRESHOLD, 32'h3f);
		acc(1, CPH_ADDR_PAUSE, 32'hff);
		sys_rst <= '1;
		repeat (2) @(posedge clk);
		sys_rst <= '0;
		@(posedge clk);
		#1 chk(pause_active, '0);
		@(posedge clk);
		acc(0, CPH_ADDR_THRESHOLD, '0);
		chk(seen, '0);
		$display("reset test done");
		print_verdict();
	end
endmodule // core_pause_forced_halt_bench
